// ==== design/swrc_pkg.sv ====
// Purpose: constants and types of the sleep, watchdog and reset control block
// Assumes: 25 MHz ref_clk, 32 kHz low power oscillator sampled as a pin
// Notes:   register byte address is four times the register index
//
// Overview of operation
// (RULE1) stop bit halts core until reset
// (RULE2) power-on reset loads status with 0x10
// (RULE3) core held off ~20 ms, starts at zero
// (RULE4) power-on flag set only by power-on reset
// (RULE5) clearing power-on flag enables watchdog permanently
// (RULE6) sleep timer on 32 kHz, interval selectable
// (RULE7) third watchdog count raises watchdog reset
// (RULE8) clear write resets watchdog, 0x38 sleep timer
// (RULE9) sleep bit stops core until interrupt/reset
// (RULE10) supply monitor duty-cycled while asleep
// (RULE11) any unmasked interrupt wakes, ignoring enable
// (RULE12) firmware keeps stop bit clear to resume
// (RULE13) sleep forces internal oscillator, fast recovery
// (RULE14) firmware moves off crystal before sleeping
// (RULE15) resume next instruction before service routine
// (RULE16) sleep timer interrupt also fires while awake
// (RULE17) sleep bit raises halt request at once
// (RULE18) acknowledge, then falling edge asserts power down
// (RULE19) power down turns off memory, oscillator, filter
// (RULE20) wake on 32 kHz fall, negate, sample
// (RULE21) halt request released on next 32 kHz fall
// (RULE22) watchdog reset sets flag, software clears only
// (RULE23) sleep timer width and interval are parameters
package swrc_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 25_000_000;  // ref_clk rate
	localparam int HOLD_MS      = 20;          // power-on hold-off in ms
	localparam int HOLD_CYC     = (HOLD_MS * CLK_HZ + 999) / 1000;
	localparam int WDR_HOLD_CYC = 16;          // core reset length after watchdog

	// ------------------------------------------------------------
	// register map (index, byte address is index times four)
	// ------------------------------------------------------------
	localparam logic [9:0]  IDX_WDT_CLR  = 10'h0E3;
	localparam logic [9:0]  IDX_STATUS   = 10'h0FF;
	localparam logic [9:0]  IDX_DUTY     = 10'h1EB;
	localparam logic [9:0]  IDX_OSC      = 10'h1F0;
	localparam logic [11:0] ADDR_WDT_CLR = {IDX_WDT_CLR, 2'b00};
	localparam logic [11:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
	localparam logic [11:0] ADDR_DUTY    = {IDX_DUTY, 2'b00};
	localparam logic [11:0] ADDR_OSC     = {IDX_OSC, 2'b00};

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int          ST_STOP    = 0;
	localparam int          ST_SLEEP   = 3;
	localparam int          ST_POWER_ON_FLAG    = 4;
	localparam int          ST_WATCHDOG_RESET_FLAG    = 5;
	localparam int          ST_GIES    = 7;
	localparam logic [7:0]  STATUS_POR = 8'h10;
	localparam logic [7:0]  WDT_KEY    = 8'h38;
	localparam int          DUTY_LSB   = 6;
	localparam logic [1:0]  DUTY_RST   = 2'h0;
	localparam logic [2:0]  OSC_RST    = 3'h0;

	// ------------------------------------------------------------
	// sleep timer and watchdog
	// ------------------------------------------------------------
	localparam int          SLP_W    = 16;        // sleep timer width
	localparam logic [15:0] SLP_BASE = 16'h0040;  // shortest interval, 64 ticks
	localparam logic [1:0]  WDT_LAST = 2'h2;      // count before the firing one

	// monitor duty period minus one, per duty code
	localparam logic [8:0]  DUTY_P128 = 9'h07F;
	localparam logic [8:0]  DUTY_P512 = 9'h1FF;
	localparam logic [8:0]  DUTY_P32  = 9'h01F;
	localparam logic [8:0]  DUTY_P8   = 9'h007;

	// sleep sequencer states
	typedef enum logic [2:0] {
		S_RUN, S_REQ, S_PDWAIT, S_SLEEP, S_WAKEPD, S_WAKESMP, S_WAKEREL
	} swrc_state_t;

endpackage

// ==== design/swrc_tmr_if.sv ====
// Purpose: link between the control logic and the sleep timer
// Assumes: both ends on ref_clk
// Notes:   all strobes are one-cycle pulses
`timescale 1ns/10ps
interface swrc_tmr_if;
	logic       lpoRise;      // 32 kHz rising edge strobe
	logic       wdtEn;        // watchdog enabled level
	logic       clrWdt;       // clear watchdog counter
	logic       clrSleep;     // clear sleep timer
	logic [2:0] intervalSel;  // sleep interval select
	logic       sleepTick;    // sleep timer overflow
	logic       wdtEvent;     // watchdog reset event

	modport ctl (output lpoRise, wdtEn, clrWdt, clrSleep, intervalSel, input sleepTick, wdtEvent);
	modport tmr (input lpoRise, wdtEn, clrWdt, clrSleep, intervalSel, output sleepTick, wdtEvent);
endinterface

// ==== design/swrc_timer.sv ====
// Purpose: sleep timer and watchdog counter
// Assumes: lpoRise is a one-cycle strobe, never two in a row
// Notes:   interval is SLP_BASE shifted left by the select
`timescale 1ns/10ps
module swrc_timer
	import swrc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	swrc_tmr_if.tmr   t
);

	logic [SLP_W-1:0] sleepCnt_r, sleepCnt_nxt;  // sleep timer count
	logic [SLP_W-1:0] term;                      // terminal count
	logic [1:0]       wdtCnt_r, wdtCnt_nxt;      // overflows since clear
	logic             tick_r, tick_nxt;          // overflow pulse
	logic             ev_r, ev_nxt;              // watchdog event pulse

	// (RULE23) width and interval from package
	assign term        = SLP_W'((SLP_BASE << t.intervalSel) - 16'h0001);
	assign t.sleepTick = tick_r;
	assign t.wdtEvent  = ev_r;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		sleepCnt_nxt = sleepCnt_r;
		wdtCnt_nxt   = wdtCnt_r;
		tick_nxt     = 1'b0;
		ev_nxt       = 1'b0;
		// (RULE6) count 32 kHz ticks
		if (t.lpoRise) begin
			if (sleepCnt_r >= term) begin
				sleepCnt_nxt = '0;
				tick_nxt     = 1'b1;
			end else begin
				sleepCnt_nxt = sleepCnt_r + 1'b1;
			end
		end
		// (RULE7) count overflows to three
		if (tick_nxt && t.wdtEn) begin
			if (wdtCnt_r == WDT_LAST) begin
				wdtCnt_nxt = '0;
				ev_nxt     = 1'b1;
			end else begin
				wdtCnt_nxt = wdtCnt_r + 1'b1;
			end
		end
		// (RULE8) clear writes win over counting
		if (t.clrWdt) begin
			wdtCnt_nxt = '0;
			ev_nxt     = 1'b0;
		end
		if (t.clrSleep) begin
			sleepCnt_nxt = '0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sleepCnt_r <= '0;
			wdtCnt_r   <= '0;
			tick_r     <= 1'b0;
			ev_r       <= 1'b0;
		end else begin
			sleepCnt_r <= sleepCnt_nxt;
			wdtCnt_r   <= wdtCnt_nxt;
			tick_r     <= tick_nxt;
			ev_r       <= ev_nxt;
		end
	end

	a_wdt_fires_third: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
		(tick_nxt && t.wdtEn && wdtCnt_r == 2'h2 && !t.clrWdt) |=> ev_r)
		else $error("watchdog did not fire on third overflow");
	a_key_clears_timer: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
		t.clrSleep |=> (sleepCnt_r == '0 && wdtCnt_r == '0 || !t.clrWdt && sleepCnt_r == '0))
		else $error("clear write left sleep timer running");
endmodule

// ==== design/swrc_top.sv ====
// Purpose: sleep, watchdog and reset control with AHB-Lite registers
// Assumes: lpoClk, cpu_clock, haltAck, irqPending, gieIn are asynchronous pins
// Notes:   rst is the power-on reset; zero wait state slave
`timescale 1ns/10ps
module swrc_top
	import swrc_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC  // power-on hold-off length
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// core and system pins
	input  wire logic        lpoClk,
	input  wire logic        cpu_clock,
	input  wire logic        haltAck,
	input  wire logic        irqPending,
	input  wire logic        gieIn,
	output logic             haltRequest,
	output logic             powerDown,
	output logic             coreReset,
	output logic             coreStop,
	output logic             oscForceInt,
	output logic             monitorEnable,
	output logic             monitorSample,
	output logic             sleepTimerIrq
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	swrc_tmr_if tif ();                         // timer link

	logic [4:0]  syncA_r;                       // first synchroniser stage
	logic [4:0]  syncB_r;                       // second synchroniser stage
	logic [1:0]  edgeC_r;                       // third stage, edge detect only
	logic        lpoRise, lpoFall, cpuFall;     // edge strobes
	logic        ackS, irqS, gieS;              // synchronised levels

	logic        wrPend_r, wrPend_nxt;          // data phase of a write
	logic [11:0] wrAddr_r, wrAddr_nxt;          // its address
	logic [31:0] hrdata_r, hrdata_nxt;          // read data
	logic        addrPhase;                     // valid address phase

	logic        power_on_flag_r, power_on_flag_nxt;              // power-on flag
	logic        watchdog_reset_flag_r, watchdog_reset_flag_nxt;              // watchdog reset flag
	logic        sleep_r, sleep_nxt;            // sleep bit
	logic        stop_r, stop_nxt;              // stop bit
	logic        wdtEn_r, wdtEn_nxt;            // watchdog enabled
	logic [1:0]  duty_r, duty_nxt;              // sleep duty field
	logic [2:0]  osc_r, osc_nxt;                // sleep interval select
	logic        clrWdt_r, clrWdt_nxt;          // watchdog clear strobe
	logic        clrSlp_r, clrSlp_nxt;          // sleep timer clear strobe
	logic        sleepSet;                      // firmware sets sleep

	swrc_state_t state_r, state_nxt;            // sleep sequencer
	logic        hreq_r, hreq_nxt;              // halt request
	logic        pd_r, pd_nxt;                  // power down
	logic        smp_r, smp_nxt;                // monitor sample pulse
	logic        wake;                          // sequencer releases core
	logic [8:0]  dutyCnt_r, dutyCnt_nxt;        // monitor duty counter
	logic [8:0]  dutyMax;                       // duty period minus one
	logic        monEn_r, monEn_nxt;            // monitor enable

	logic [19:0] hold_r, hold_nxt;              // core hold-off count
	logic        crst_r, crst_nxt;              // core reset
	logic        cstop_r, cstop_nxt;            // core stop
	logic        irq_r, irq_nxt;                // sleep timer interrupt
	logic        watchdog_reset_event;                           // watchdog reset event

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// two flops per pin; a third flop only feeds the edge detectors
	always_ff @(posedge ref_clk) begin
		syncA_r <= {gieIn, irqPending, haltAck, cpu_clock, lpoClk};
		syncB_r <= syncA_r;
		edgeC_r <= syncB_r[1:0];
	end

	assign lpoRise = syncB_r[0] & ~edgeC_r[0];
	assign lpoFall = ~syncB_r[0] & edgeC_r[0];
	assign cpuFall = ~syncB_r[1] & edgeC_r[1];
	assign ackS    = syncB_r[2];
	assign irqS    = syncB_r[3];
	assign gieS    = syncB_r[4];
	assign watchdog_reset_event     = tif.wdtEvent;

	// ------------------------------------------------------------
	// timer instance
	// ------------------------------------------------------------
	assign tif.lpoRise     = lpoRise;
	assign tif.wdtEn       = wdtEn_r;
	assign tif.clrWdt      = clrWdt_r;
	assign tif.clrSleep    = clrSlp_r;
	assign tif.intervalSel = osc_r;

	swrc_timer u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.t       (tif.tmr)
	);

	// ------------------------------------------------------------
	// bus slave and registers, next values
	// ------------------------------------------------------------
	assign addrPhase = hsel && htrans[1] && hready;
	assign sleepSet  = wrPend_r && wrAddr_r == ADDR_STATUS && hwdata[ST_SLEEP];

	always_comb begin
		wrPend_nxt = addrPhase && hwrite;
		wrAddr_nxt = addrPhase ? haddr : wrAddr_r;
		hrdata_nxt = hrdata_r;
		power_on_flag_nxt   = power_on_flag_r;
		watchdog_reset_flag_nxt   = watchdog_reset_flag_r;
		sleep_nxt  = sleep_r;
		stop_nxt   = stop_r;
		duty_nxt   = duty_r;
		osc_nxt    = osc_r;
		clrWdt_nxt = 1'b0;
		clrSlp_nxt = 1'b0;
		// read data is fetched in the address phase, zero for holes
		if (addrPhase && !hwrite) begin
			unique case (haddr)
				ADDR_STATUS: hrdata_nxt = {24'h000000, gieS, 1'b0, watchdog_reset_flag_r, power_on_flag_r, sleep_r, 2'b00, stop_r};
				ADDR_DUTY:   hrdata_nxt = {24'h000000, duty_r, 6'h00};
				ADDR_OSC:    hrdata_nxt = {29'h00000000, osc_r};
				default:     hrdata_nxt = 32'h00000000;
			endcase
		end
		// writes land in their data phase
		if (wrPend_r) begin
			unique case (wrAddr_r)
				ADDR_STATUS: begin
					// (RULE4) flags clear only, never set
					power_on_flag_nxt  = power_on_flag_r & hwdata[ST_POWER_ON_FLAG];
					watchdog_reset_flag_nxt  = watchdog_reset_flag_r & hwdata[ST_WATCHDOG_RESET_FLAG];
					sleep_nxt = hwdata[ST_SLEEP];
					// (RULE1) stop sticks until reset
					stop_nxt  = stop_r | hwdata[ST_STOP];
				end
				ADDR_DUTY:   duty_nxt = hwdata[DUTY_LSB +: 2];
				ADDR_OSC:    osc_nxt = hwdata[2:0];
				ADDR_WDT_CLR: begin
					// (RULE8) any write clears, key clears timer too
					clrWdt_nxt = 1'b1;
					clrSlp_nxt = hwdata[7:0] == WDT_KEY;
				end
				default: ;
			endcase
		end
		// hardware clears sleep once the core is released
		if (wake) begin
			sleep_nxt = 1'b0;
		end
		// (RULE22) watchdog reset sets its flag over a clear
		if (watchdog_reset_event) begin
			watchdog_reset_flag_nxt  = 1'b1;
			sleep_nxt = 1'b0;
			stop_nxt  = 1'b0;
			duty_nxt  = DUTY_RST;
			osc_nxt   = OSC_RST;
		end
	end

	// (RULE5) watchdog enable never drops before power-on reset
	assign wdtEn_nxt = wdtEn_r | ~power_on_flag_r;

	// ------------------------------------------------------------
	// bus and register flops
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 12'h000;
			hrdata_r <= 32'h00000000;
			// (RULE2) power-on status pattern
			{watchdog_reset_flag_r, power_on_flag_r, sleep_r, stop_r} <= {STATUS_POR[ST_WATCHDOG_RESET_FLAG], STATUS_POR[ST_POWER_ON_FLAG],
				STATUS_POR[ST_SLEEP], STATUS_POR[ST_STOP]};
			wdtEn_r  <= 1'b0;
			duty_r   <= DUTY_RST;
			osc_r    <= OSC_RST;
			clrWdt_r <= 1'b0;
			clrSlp_r <= 1'b0;
		end else begin
			wrPend_r <= wrPend_nxt;
			wrAddr_r <= wrAddr_nxt;
			hrdata_r <= hrdata_nxt;
			power_on_flag_r   <= power_on_flag_nxt;
			watchdog_reset_flag_r   <= watchdog_reset_flag_nxt;
			sleep_r  <= sleep_nxt;
			stop_r   <= stop_nxt;
			wdtEn_r  <= wdtEn_nxt;
			duty_r   <= duty_nxt;
			osc_r    <= osc_nxt;
			clrWdt_r <= clrWdt_nxt;
			clrSlp_r <= clrSlp_nxt;
		end
	end

	// ------------------------------------------------------------
	// sleep sequencer, next values
	// ------------------------------------------------------------
	assign wake = state_r == S_WAKEREL && lpoFall;

	always_comb begin
		state_nxt = state_r;
		hreq_nxt  = hreq_r;
		pd_nxt    = pd_r;
		smp_nxt   = 1'b0;
		unique case (state_r)
			S_RUN: begin
				// (RULE17) request goes out with the write itself
				if (sleepSet) begin
					hreq_nxt  = 1'b1;
					state_nxt = S_REQ;
				end
			end
			S_REQ: begin
				// (RULE18) core acknowledges at an instruction boundary
				if (ackS) begin
					state_nxt = S_PDWAIT;
				end
			end
			S_PDWAIT: begin
				// (RULE19) power down on the next cpu clock fall
				if (cpuFall) begin
					pd_nxt    = 1'b1;
					state_nxt = S_SLEEP;
				end
			end
			S_SLEEP: begin
				// (RULE11) any pending interrupt wakes, enable ignored
				if (irqS && lpoFall) begin
					state_nxt = S_WAKEPD;
				end
			end
			S_WAKEPD: begin
				// (RULE20) power returns on the next 32 kHz rise
				if (lpoRise) begin
					pd_nxt    = 1'b0;
					state_nxt = S_WAKESMP;
				end
			end
			S_WAKESMP: begin
				// supply monitors settle and are sampled
				if (lpoRise) begin
					smp_nxt   = 1'b1;
					state_nxt = S_WAKEREL;
				end
			end
			S_WAKEREL: begin
				// (RULE21) release on the next 32 kHz fall
				// (RULE15) core resumes after the sleep instruction
				if (lpoFall) begin
					hreq_nxt  = 1'b0;
					state_nxt = S_RUN;
				end
			end
		endcase
		// (RULE9) only a reset aborts sleep besides an interrupt
		if (watchdog_reset_event) begin
			hreq_nxt  = 1'b0;
			pd_nxt    = 1'b0;
			state_nxt = S_RUN;
		end
	end

	// (RULE10) monitors run one period in dutyMax+1 while asleep
	always_comb begin
		unique case (duty_r)
			2'h0: dutyMax = DUTY_P128;
			2'h1: dutyMax = DUTY_P512;
			2'h2: dutyMax = DUTY_P32;
			2'h3: dutyMax = DUTY_P8;
		endcase
		dutyCnt_nxt = dutyCnt_r;
		if (!pd_r) begin
			dutyCnt_nxt = 9'h000;
		end else if (lpoRise) begin
			dutyCnt_nxt = (dutyCnt_r >= dutyMax) ? 9'h000 : dutyCnt_r + 9'h001;
		end
		monEn_nxt = !pd_r || dutyCnt_nxt == 9'h000;
	end

	// ------------------------------------------------------------
	// core reset, stop and interrupt, next values
	// ------------------------------------------------------------
	always_comb begin
		hold_nxt  = hold_r;
		crst_nxt  = hold_r != 20'h00000;
		// (RULE3) hold-off counts down, core then fetches from zero
		if (hold_r != 20'h00000) begin
			hold_nxt = hold_r - 20'h00001;
		end
		if (watchdog_reset_event) begin
			hold_nxt = 20'(WDR_HOLD_CYC);
			crst_nxt = 1'b1;
		end
		// (RULE12) core runs only with stop clear
		cstop_nxt = stop_nxt;
		// (RULE16) overflow interrupt, awake or asleep
		irq_nxt   = tif.sleepTick;
	end

	// ------------------------------------------------------------
	// sequencer and output flops
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r   <= S_RUN;
			hreq_r    <= 1'b0;
			pd_r      <= 1'b0;
			smp_r     <= 1'b0;
			dutyCnt_r <= 9'h000;
			monEn_r   <= 1'b1;
			hold_r    <= 20'(HOLD_CYCLES);
			crst_r    <= 1'b1;
			cstop_r   <= 1'b0;
			irq_r     <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			hreq_r    <= hreq_nxt;
			pd_r      <= pd_nxt;
			smp_r     <= smp_nxt;
			dutyCnt_r <= dutyCnt_nxt;
			monEn_r   <= monEn_nxt;
			hold_r    <= hold_nxt;
			crst_r    <= crst_nxt;
			cstop_r   <= cstop_nxt;
			irq_r     <= irq_nxt;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// outputs straight from flops
	assign hrdata        = hrdata_r;
	assign haltRequest   = hreq_r;
	assign powerDown     = pd_r;
	assign coreReset     = crst_r;
	assign coreStop      = cstop_r;
	// (RULE13) internal oscillator forced for the whole sleep
	assign oscForceInt   = hreq_r;
	assign monitorEnable = monEn_r;
	assign monitorSample = smp_r;
	assign sleepTimerIrq = irq_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_por_pattern: assert property ($past(rst) |-> power_on_flag_r && !watchdog_reset_flag_r && !sleep_r && !stop_r) // RULE2
		else $error("status not 0x10 after power-on reset");
	a_power_on_flag_no_set: assert property (!power_on_flag_r |=> !power_on_flag_r) // RULE4
		else $error("power-on flag set by software");
	a_wdt_sticky: assert property (!power_on_flag_r |=> wdtEn_r ##1 wdtEn_r) // RULE5
		else $error("watchdog not held enabled");
	a_stop_halts: assert property (stop_r && !watchdog_reset_event |=> coreStop) // RULE1
		else $error("stop bit did not halt core");
	a_sleep_request: assert property (state_r == S_RUN && sleepSet && !watchdog_reset_event |=> haltRequest) // RULE17
		else $error("halt request late after sleep write");
	a_pd_after_ack: assert property (state_r == S_PDWAIT && cpuFall && !watchdog_reset_event |=> powerDown) // RULE18
		else $error("power down missed cpu clock fall");
	a_wake_negate: assert property (state_r == S_WAKEPD && lpoRise && !watchdog_reset_event |=> !powerDown ##0 !monitorSample) // RULE20
		else $error("power down not negated on 32 kHz rise");
	a_release_req: assert property (wake && !watchdog_reset_event |=> !haltRequest && !sleep_r) // RULE21
		else $error("halt request not released");
	a_holdoff_core: assert property (hold_r != 20'h00000 |=> coreReset) // RULE3
		else $error("core released during hold-off");
	a_wdr_flag: assert property (watchdog_reset_event |=> watchdog_reset_flag_r && coreReset) // RULE22
		else $error("watchdog reset not recorded");
endmodule

// ==== tb/swrc_core_model.sv ====
// Purpose: cpu core stand-in answering the halt handshake
// Assumes: core clock stops while power down is high
// Notes:   acknowledge lags the sampled request by one core edge
`timescale 1ns/10ps
module swrc_core_model (
	input  wire logic haltRequest,
	input  wire logic powerDown,
	output logic      cpu_clock,
	output logic      haltAck
);
	logic seen;  // request seen at the previous core edge

	// core clock, parked low in power down since its oscillator is off
	initial begin
		cpu_clock = 1'b0;
		forever #35 cpu_clock = ~cpu_clock & ~powerDown;
	end

	always @(posedge cpu_clock) begin
		seen    <= haltRequest;
		haltAck <= haltRequest & seen;
	end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the sleep, watchdog and reset block
// Assumes: fast 32 kHz stand-in of 16 ref cycles, hold-off shortened
// Notes:   firmware keeps stop bit clear until the final stop test and runs on internal clock
`timescale 1ns/10ps
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module tb_top;
	import swrc_pkg::*;
	localparam int HOLD = 50;  // shortened hold-off
	localparam int LPO  = 16;  // ref cycles per 32 kHz period
	logic        ref_clk, rst, hsel, hwrite, lpoClk, irqPending, gieIn, global_irq_enable;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata;
	logic        hreadyout, hresp, cpu_clock, haltAck, haltRequest, powerDown;
	logic        coreReset, coreStop, oscForceInt, monitorEnable, monitorSample, sleepTimerIrq;
	int          miscompares, samplesChecked, seed;

	swrc_top #(.HOLD_CYCLES(HOLD)) dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lpoClk(lpoClk), .cpu_clock(cpu_clock),
		.haltAck(haltAck), .irqPending(irqPending), .gieIn(gieIn), .haltRequest(haltRequest),
		.powerDown(powerDown), .coreReset(coreReset), .coreStop(coreStop), .oscForceInt(oscForceInt),
		.monitorEnable(monitorEnable), .monitorSample(monitorSample), .sleepTimerIrq(sleepTimerIrq));
	swrc_core_model core (.haltRequest(haltRequest), .powerDown(powerDown), .cpu_clock(cpu_clock), .haltAck(haltAck));

	// ------------------------------------------------------------
	// clocks and closing
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		lpoClk = 1'b0;
		#13;
		forever #(LPO * 20) lpoClk = ~lpoClk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, well beyond the longest watchdog wait
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		stop_test();
	end

	// ------------------------------------------------------------
	// bus tasks, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic busXfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		`CHK("hreadyout", 1'b1, hreadyout)
		hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		busXfer(1'b1, a, {24'h0, d});
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
		busXfer(1'b0, a, 32'h0);
		`CHK("hrdata", {24'h0, e}, hrdata)
	endtask
	// one sleep interval in ref cycles: base tick count shifted by the select
	function automatic int ivCycles(input logic s);
		return (int'(SLP_BASE) * LPO) << s;
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int i, n, iv;
		logic [7:0] cv;
		logic [1:0] duty;
		logic sel;
		seed = 68; miscompares = 0; samplesChecked = 0;
		rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; haddr = 12'h0; htrans = 2'b00; hwdata = 32'h0;
		irqPending = 1'b0; gieIn = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		global_irq_enable = $random(seed);
		gieIn <= global_irq_enable;
		repeat (HOLD - 5) @(posedge ref_clk);
		`CHK("coreReset", 1'b1, coreReset)
		repeat (10) @(posedge ref_clk);
		`CHK("coreReset", 1'b0, coreReset)
		rdChk(ADDR_STATUS, {global_irq_enable, 7'h10});
		rdChk(12'h004, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		rdChk(ADDR_STATUS, {global_irq_enable, 7'h00});
		wr(ADDR_STATUS, 8'h10);
		rdChk(ADDR_STATUS, {global_irq_enable, 7'h00});
		duty = $random(seed);
		wr(ADDR_DUTY, {duty, 6'h0});
		rdChk(ADDR_DUTY, {duty, 6'h0});
		// overflow count per interval, both timers cleared by the key
		sel = $random(seed);
		iv = ivCycles(sel);
		wr(ADDR_OSC, {7'h0, sel});
		wr(ADDR_WDT_CLR, WDT_KEY);
		n = 0;
		for (i = 0; i < 2500; i++) begin
			@(posedge ref_clk);
			if (sleepTimerIrq === 1'b1) n++;
		end
		`CHK("sleepTimerIrq", 2500 / iv, n)
		`CHK("coreReset", 1'b0, coreReset)
		// plain clear keeps the sleep timer phase, bite in two to three intervals
		cv = $random(seed);
		if (cv == WDT_KEY) cv = 8'h37;
		wr(ADDR_WDT_CLR, cv);
		repeat (2 * iv - 100) @(posedge ref_clk);
		`CHK("coreReset", 1'b0, coreReset)
		for (i = 0; i < iv + 300 && coreReset !== 1'b1; i++) @(posedge ref_clk);
		`CHK("coreReset", 1'b1, coreReset)
		for (i = 0; i < 100 && coreReset !== 1'b0; i++) @(posedge ref_clk);
		rdChk(ADDR_STATUS, {global_irq_enable, 7'h20});
		wr(ADDR_STATUS, 8'h00);
		rdChk(ADDR_STATUS, {global_irq_enable, 7'h00});
		// sleep from the internal clock, enable off to show it is ignored
		gieIn <= 1'b0;
		wr(ADDR_DUTY, {duty, 6'h0});
		wr(ADDR_WDT_CLR, WDT_KEY);
		wr(ADDR_STATUS, 8'h08); // stop kept clear
		for (i = 0; i < 3 && haltRequest !== 1'b1; i++) @(posedge ref_clk);
		`CHK("haltRequest", 1'b1, haltRequest)
		`CHK("oscForceInt", 1'b1, oscForceInt)
		for (i = 0; i < 100 && powerDown !== 1'b1; i++) @(posedge ref_clk);
		`CHK("powerDown", 1'b1, powerDown)
		repeat (3 * LPO) @(posedge ref_clk);
		`CHK("haltRequest", 1'b1, haltRequest)
		`CHK("monitorEnable", 1'b0, monitorEnable)
		irqPending <= 1'b1;
		for (i = 0; i < 3 * LPO && powerDown !== 1'b0; i++) @(posedge ref_clk);
		`CHK("powerDown", 1'b0, powerDown)
		for (i = 0; i < 2 * LPO && monitorSample !== 1'b1; i++) @(posedge ref_clk);
		`CHK("monitorSample", 1'b1, monitorSample)
		for (i = 0; i < 2 * LPO && haltRequest !== 1'b0; i++) @(posedge ref_clk);
		`CHK("haltRequest", 1'b0, haltRequest)
		irqPending <= 1'b0;
		repeat (5) @(posedge ref_clk);
		`CHK("monitorEnable", 1'b1, monitorEnable)
		rdChk(ADDR_STATUS, 8'h00);
		// stop bit holds the core until a reset
		wr(ADDR_STATUS, 8'h01);
		repeat (3) @(posedge ref_clk);
		`CHK("coreStop", 1'b1, coreStop)
		wr(ADDR_STATUS, 8'h00);
		repeat (3) @(posedge ref_clk);
		`CHK("coreStop", 1'b1, coreStop)
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		`CHK("coreStop", 1'b0, coreStop)
		rdChk(ADDR_STATUS, 8'h10);
		stop_test();
	end
endmodule
